// >>> tps_fuse_array.sv
// fuse store: pattern rows, start-address rows and control row
// assumes programming strobes come from logic on sys_clk
`timescale 1ns/1ps
module tps_fuse_array
    import tps_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    input  wire logic                       prog_mode,
    input  wire logic                       prog_pulse,
    input  wire logic [tps_pkg::ROW_W-1:0]  prog_row,
    input  wire logic [tps_pkg::COL_W-1:0]  prog_col,
    input  wire logic                       prog_data,
    output logic                            verify_data,
    input  wire logic [tps_pkg::ADDR_W-1:0] rd_addr,
    output logic [tps_pkg::WORD_W-1:0]      rd_word,
    input  wire logic [tps_pkg::SEL_W-1:0]  start_select,
    output logic [tps_pkg::ADDR_W-1:0]      start_addr,
    output logic [tps_pkg::CTRL_W-1:0]      ctrl_fuses
);
    logic [WORD_W-1:0] pat_mem [PAT_ROWS];
    logic [ADDR_W-1:0] start_mem [START_ROWS];
    logic [CTRL_W-1:0] ctrl_reg;
    logic              hit_pat;
    logic              hit_start;
    logic              hit_ctrl;
    logic              sel_bit;

    // row decode of the fuse matrix
    assign hit_pat   = (prog_row < 6'(PAT_ROWS)) && (prog_col <= 5'(STOP_COL));
    assign hit_start = (prog_row >= START_ROW_BASE) && (prog_row <= START_ROW_LAST)
                       && (prog_col < 5'(ADDR_W));
    assign hit_ctrl  = (prog_row == CTRL_ROW) && (prog_col >= CTRL_COL_BASE)
                       && (prog_col <= CTRL_COL_LAST);

    // blank fuses read 0, so a blank row gives low outputs and next address 0
    // a pulse can only blow a fuse, never restore one
    generate
        for (genvar r = 0; r < PAT_ROWS; r++)
        begin : g_pat
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                    pat_mem[r] <= '0;
                else if (prog_mode && prog_pulse && prog_data && hit_pat
                         && prog_row == 6'(r))
                    pat_mem[r][prog_col] <= 1'b1;
            end
        end
        for (genvar s = 0; s < START_ROWS; s++)
        begin : g_start
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                    start_mem[s] <= '0;
                else if (prog_mode && prog_pulse && prog_data && hit_start
                         && prog_row == START_ROW_BASE + 6'(s))
                    start_mem[s][prog_col[2:0]] <= 1'b1;
            end
        end
    endgenerate

    // control row, columns 23..29 map to the seven control fuses
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            ctrl_reg <= '0;
        else if (prog_mode && prog_pulse && prog_data && hit_ctrl)
            ctrl_reg[3'(prog_col - CTRL_COL_BASE)] <= 1'b1;
    end

    // verify readback of the addressed fuse
    always_comb
    begin
        sel_bit = 1'b0;
        if (hit_pat)
            sel_bit = pat_mem[prog_row[4:0]][prog_col];
        else if (hit_start)
            sel_bit = start_mem[prog_row[2:0]][prog_col[2:0]];
        else if (hit_ctrl)
            sel_bit = ctrl_reg[3'(prog_col - CTRL_COL_BASE)];
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            verify_data <= 1'b0;
        else
            verify_data <= prog_mode & sel_bit;
    end

    assign rd_word    = pat_mem[rd_addr];
    assign start_addr = start_mem[start_select];
    assign ctrl_fuses = ctrl_reg;
endmodule : tps_fuse_array

// >>> tps_pkg.sv
// constants for the triggered pattern sequencer: fuse map, widths, reset values
// assumes one clock domain; fuse array lives in tps_fuse_array
package tps_pkg;
    localparam int          OUT_W          = 12;
    localparam int          ADDR_W         = 5;
    localparam int          WORD_W         = 18;
    localparam int          ROW_W          = 6;
    localparam int          COL_W          = 5;
    localparam int          SEL_W          = 3;
    localparam int          PAT_ROWS       = 32;
    localparam int          START_ROWS     = 8;
    // field positions inside one pattern row
    localparam int          NEXT_LSB       = 0;
    localparam int          OUT_LSB        = 5;
    localparam int          STOP_COL       = 17;
    // fuse matrix rows and columns
    localparam logic [5:0]  START_ROW_BASE = 6'h20;
    localparam logic [5:0]  START_ROW_LAST = 6'h27;
    localparam logic [5:0]  CTRL_ROW       = 6'h28;
    localparam logic [4:0]  CTRL_COL_BASE  = 5'h17;
    localparam logic [4:0]  CTRL_COL_LAST  = 5'h1d;
    localparam int          CTRL_W         = 7;
    // control fuse bit positions (columns 23..29 in order)
    localparam int          F_DIV2         = 0;
    localparam int          F_DIV4         = 1;
    localparam int          F_BYPASS       = 2;
    localparam int          F_MUL5         = 3;
    localparam int          F_REF5         = 4;
    localparam int          F_FALLING      = 5;
    localparam int          F_NO_TRAIL     = 6;
    // reset values
    localparam logic [11:0] OUT_RESET      = 12'h000;
    localparam logic [4:0]  ADDR_RESET     = 5'h00;
    // clock figures
    localparam int          SYS_CLK_MHZ    = 100;
    localparam int          D_FAST_MHZ     = 50;
    localparam logic [1:0]  D_SLOW_CYCLES  = 2'h1;
    localparam logic [1:0]  D_FAST_CYCLES  = 2'h2;
    localparam logic [3:0]  REF_HALF_10    = 4'ha;
    localparam logic [3:0]  REF_HALF_5     = 4'h5;
    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN, ST_HOLD} tps_state_type;
endpackage : tps_pkg

// >>> tps_sequencer.sv
// trigger-started pattern sequencer top: trigger machine, clock logic, output register
// assumes start_pulse_in and start_select are asynchronous pins; everything else is
// on sys_clk, which stands for the input frequency
`timescale 1ns/1ps
module tps_sequencer
    import tps_pkg::*;
#(
    parameter int INPUT_FREQ_MHZ = tps_pkg::SYS_CLK_MHZ
)
(
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    input  wire logic                       sync_reset,
    input  wire logic                       start_pulse_in,
    input  wire logic [tps_pkg::SEL_W-1:0]  start_select,
    output logic [tps_pkg::OUT_W-1:0]       timing_outputs,
    output logic                            gated_state_clock,
    output logic                            select_out,
    output logic                            reference_clock_out,
    output logic                            running,
    input  wire logic                       prog_mode,
    input  wire logic                       prog_pulse,
    input  wire logic [tps_pkg::ROW_W-1:0]  prog_row,
    input  wire logic [tps_pkg::COL_W-1:0]  prog_col,
    input  wire logic                       prog_data,
    output logic                            verify_data
);
    tps_state_type     state_reg;
    logic [2:0]        start_pulse_in_sync_reg;
    logic [SEL_W-1:0]  sel_meta_reg;
    logic [SEL_W-1:0]  sel_sync_reg;
    logic              edge_pend_reg;
    logic [1:0]        div_cnt_reg;
    logic [1:0]        hold_cnt_reg;
    logic [3:0]        ref_cnt_reg;
    logic [ADDR_W-1:0] next_addr_reg;
    logic              stop_bit_reg;
    logic [WORD_W-1:0] rd_word;
    logic [ADDR_W-1:0] start_addr;
    logic [CTRL_W-1:0] ctrl_fuses;
    logic              start_pulse_in_level;
    logic              start_pulse_in_prev;
    logic              active_edge;
    logic              alt_tick;
    logic              trail_stop;
    logic [1:0]        div_last;
    logic [1:0]        hold_last;
    logic [3:0]        ref_half;
    logic [ADDR_W-1:0] rd_sel_addr;
    logic              hold_done;

    tps_fuse_array u_fuses
    (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .prog_mode    (prog_mode),
        .prog_pulse   (prog_pulse),
        .prog_row     (prog_row),
        .prog_col     (prog_col),
        .prog_data    (prog_data),
        .verify_data  (verify_data),
        .rd_addr      (rd_sel_addr),
        .rd_word      (rd_word),
        .start_select (sel_sync_reg),
        .start_addr   (start_addr),
        .ctrl_fuses   (ctrl_fuses)
    );

    // two flops on the pins; the third trigger flop only serves edge detection
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            start_pulse_in_sync_reg <= 3'h0;
            sel_meta_reg  <= '0;
            sel_sync_reg  <= '0;
        end
        else
        begin
            start_pulse_in_sync_reg <= {start_pulse_in_sync_reg[1:0], start_pulse_in};
            sel_meta_reg  <= start_select;
            sel_sync_reg  <= sel_meta_reg;
        end
    end

    // polarity fuse turns the pin into an active level
    assign start_pulse_in_level  = start_pulse_in_sync_reg[1] ^ ctrl_fuses[F_FALLING];
    assign start_pulse_in_prev   = start_pulse_in_sync_reg[2] ^ ctrl_fuses[F_FALLING];
    assign active_edge = start_pulse_in_level & ~start_pulse_in_prev;
    // trailing level is a stop only while the no-trail fuse is blank
    assign trail_stop  = ~ctrl_fuses[F_NO_TRAIL] & ~start_pulse_in_level;

    // divider select; the illegal both-set code falls back to no division
    always_comb
    begin
        div_last = 2'h0;
        if (!ctrl_fuses[F_BYPASS] && ctrl_fuses[F_DIV2] && !ctrl_fuses[F_DIV4])
            div_last = 2'h1;
        else if (!ctrl_fuses[F_BYPASS] && ctrl_fuses[F_DIV4] && !ctrl_fuses[F_DIV2])
            div_last = 2'h3;
    end

    // free-running divider; its phase at trigger time is the fractional uncertainty
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            div_cnt_reg <= 2'h0;
        else if (div_cnt_reg >= div_last)
            div_cnt_reg <= 2'h0;
        else
            div_cnt_reg <= div_cnt_reg + 2'h1;
    end

    // altered clock as a tick; the loop is modelled at the input rate
    assign alt_tick = (div_cnt_reg >= div_last);

    // hold length depends on the internal rate
    assign hold_last = ((INPUT_FREQ_MHZ / (int'(div_last) + 1)) > D_FAST_MHZ)
                       ? D_FAST_CYCLES : D_SLOW_CYCLES;

    // hold has run its length once the counter reaches the rate-dependent end
    assign hold_done = (hold_cnt_reg >= hold_last);

    // select high reads the start table, select low follows the stored next address
    assign rd_sel_addr = (state_reg == ST_IDLE || state_reg == ST_ARM)
                         ? start_addr : next_addr_reg;

    // active edge is remembered until the machine consumes it; a new edge wins over the clear
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            edge_pend_reg <= 1'b0;
        else if (active_edge)
            edge_pend_reg <= 1'b1;
        else if (prog_mode || sync_reset || (alt_tick && state_reg == ST_ARM))
            edge_pend_reg <= 1'b0;
    end

    // trigger machine, moves on altered clock ticks; sync_reset and prog_mode force idle on any clock
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg    <= ST_IDLE;
            hold_cnt_reg <= 2'h0;
        end
        else if (sync_reset || prog_mode)
        begin
            state_reg    <= ST_IDLE;
            hold_cnt_reg <= 2'h0;
        end
        else if (alt_tick)
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (edge_pend_reg)
                        state_reg <= ST_ARM;
                end
                ST_ARM:
                    state_reg <= ST_RUN;
                ST_RUN:
                begin
                    // no restart is taken here; a new edge waits for hold
                    if (stop_bit_reg || trail_stop)
                    begin
                        state_reg    <= ST_HOLD;
                        hold_cnt_reg <= 2'h1;
                    end
                end
                ST_HOLD:
                begin
                    if (!hold_done)
                        hold_cnt_reg <= hold_cnt_reg + 2'h1;
                    else if (edge_pend_reg)
                        state_reg <= ST_ARM;
                    else
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // output register: loaded on leaving arm and on each run tick without a stored stop
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timing_outputs <= OUT_RESET;
            next_addr_reg  <= ADDR_RESET;
            stop_bit_reg   <= 1'b0;
        end
        else if (!sync_reset && !prog_mode && alt_tick)
        begin
            if (state_reg == ST_ARM)
            begin
                // start word comes through the start-address table
                timing_outputs <= out_field(rd_word);
                next_addr_reg  <= next_field(rd_word);
                stop_bit_reg   <= stop_field(rd_word);
            end
            else if (state_reg == ST_RUN && !stop_bit_reg)
            begin
                // a stored stop freezes the word that carried it
                // a trailing stop still takes this word, giving start-equal latency
                timing_outputs <= rd_word[OUT_LSB +: OUT_W];
                next_addr_reg  <= rd_word[NEXT_LSB +: ADDR_W];
                stop_bit_reg   <= rd_word[STOP_COL];
            end
        end
    end

    // field slices of one pattern row; the start word comes through the same read port,
    // addressed from the start table while select is high, so no second port is needed
    function automatic logic [OUT_W-1:0] out_field(input logic [WORD_W-1:0] w);
        out_field = w[OUT_LSB +: OUT_W];
    endfunction : out_field

    function automatic logic [ADDR_W-1:0] next_field(input logic [WORD_W-1:0] w);
        next_field = w[NEXT_LSB +: ADDR_W];
    endfunction : next_field

    function automatic logic stop_field(input logic [WORD_W-1:0] w);
        stop_field = w[STOP_COL];
    endfunction : stop_field

    // gated clock: high in idle, pulses per tick in arm and run, low in hold
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gated_state_clock <= 1'b1;
            running           <= 1'b0;
        end
        else
        begin
            gated_state_clock <= (state_reg == ST_IDLE) ||
                                 ((state_reg == ST_ARM || state_reg == ST_RUN) && alt_tick);
            running           <= (state_reg != ST_IDLE);
        end
    end

    // select tracks the next state, so it drops at the very edge that loads the start word
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            select_out <= 1'b1;
        else if (sync_reset || prog_mode)
            select_out <= 1'b1;
        else if (alt_tick)
            select_out <= (state_reg == ST_IDLE) || (state_reg == ST_HOLD && hold_done);
    end

    // reference clock: loop rate divided by twenty or ten, not valid in bypass
    assign ref_half = ctrl_fuses[F_REF5] ? REF_HALF_5 : REF_HALF_10;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ref_cnt_reg         <= 4'h0;
            reference_clock_out <= 1'b0;
        end
        else if (ctrl_fuses[F_BYPASS] || prog_mode)
        begin
            ref_cnt_reg         <= 4'h0;
            reference_clock_out <= 1'b0;
        end
        else if (ref_cnt_reg + 4'h1 >= ref_half)
        begin
            ref_cnt_reg         <= 4'h0;
            reference_clock_out <= ~reference_clock_out;
        end
        else
            ref_cnt_reg <= ref_cnt_reg + 4'h1;
    end
endmodule : tps_sequencer

// >>> tps_sequencer_chk.sv
// port assertions for the triggered pattern sequencer
// assumes one sys_clk domain; bound to every tps_sequencer instance
`timescale 1ns/1ps
module tps_sequencer_chk
    import tps_pkg::*;
(
    input wire logic                      sys_clk,
    input wire logic                      resetn,
    input wire logic                      sync_reset,
    input wire logic [tps_pkg::OUT_W-1:0] timing_outputs,
    input wire logic                      gated_state_clock,
    input wire logic                      select_out,
    input wire logic                      running,
    input wire logic                      prog_mode,
    input wire logic                      prog_pulse,
    input wire logic [tps_pkg::ROW_W-1:0] prog_row,
    input wire logic [tps_pkg::COL_W-1:0] prog_col,
    input wire logic                      prog_data,
    input wire logic                      verify_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // outputs start low and move only while select is low
    reset_low_a: assert property ($rose(resetn) |-> timing_outputs == OUT_RESET)
        else $error("outputs not low after reset");
    out_quiet_idle_a: assert property ($changed(timing_outputs) |-> !select_out)
        else $error("outputs changed while select high");
    select_run_a: assert property (!select_out |-> running)
        else $error("select low outside a sequence");
    idle_after_run_a: assert property ($fell(running) |-> select_out)
        else $error("select not high after stop");
    // hold lasts two ticks at this rate; forced idle excused
    hold_len_a: assert property ($fell(gated_state_clock) && !select_out
        |=> !gated_state_clock || $past(sync_reset) || $past(prog_mode))
        else $error("hold state too short");
    // synchronous reset drops to idle without clocking outputs
    sync_idle_a: assert property (sync_reset |-> ##[1:2] select_out)
        else $error("sync reset did not reach idle");
    sync_keep_a: assert property (sync_reset |=> $stable(timing_outputs))
        else $error("sync reset clocked outputs");
    // fuse access: blow then read back, quiet outside program mode
    fuse_blow_a: assert property ((prog_mode && prog_pulse && prog_data) ##1
        (prog_mode && $stable(prog_row) && $stable(prog_col)) |=> verify_data)
        else $error("blown fuse not read back");
    verify_idle_a: assert property (!prog_mode && !$past(prog_mode) |-> !verify_data)
        else $error("verify data outside program mode");
endmodule : tps_sequencer_chk

bind tps_sequencer tps_sequencer_chk u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .sync_reset(sync_reset),
    .timing_outputs(timing_outputs), .gated_state_clock(gated_state_clock),
    .select_out(select_out), .running(running), .prog_mode(prog_mode),
    .prog_pulse(prog_pulse), .prog_row(prog_row), .prog_col(prog_col),
    .prog_data(prog_data), .verify_data(verify_data)
);

// >>> tps_start_pulse_in_model.sv
// far-side system logic: trigger pulses of a set length and polarity
// assumes the bench requests a pulse only once the last pulse ended
`timescale 1ns/1ps
module tps_start_pulse_in_model
(
    input  wire logic       sys_clk,
    input  wire logic       fire,
    input  wire logic [7:0] pulse_len,
    input  wire logic       active_low,
    output logic            start_pulse_in,
    output logic            busy
);
    logic [7:0] count_reg = 8'h00;

    // pulse counter; a new request is ignored while a pulse is out
    always_ff @(posedge sys_clk)
    begin
        if (fire && count_reg == 8'h00)
            count_reg <= pulse_len;
        else if (count_reg != 8'h00)
            count_reg <= count_reg - 8'h01;
    end

    // pin rests at the inactive level between pulses
    assign busy           = (count_reg != 8'h00);
    assign start_pulse_in = busy ^ active_low;
endmodule : tps_start_pulse_in_model

// >>> triggered_pattern_sequencer_tb_top.sv
// self-checking bench: fuse programming, triggered runs, stops, resets
// assumes the trigger model drives the pin synchronously to sys_clk
`timescale 1ns/1ps
module triggered_pattern_sequencer_tb_top;
    import tps_pkg::*;
    logic             sys_clk      = 1'b0;
    logic             resetn       = 1'b0;
    logic             sync_reset   = 1'b0;
    logic [SEL_W-1:0] start_select = 3'h0;
    logic             prog_mode    = 1'b0;
    logic             prog_pulse   = 1'b0;
    logic             prog_data    = 1'b0;
    logic [ROW_W-1:0] prog_row     = 6'h00;
    logic [COL_W-1:0] prog_col     = 5'h00;
    logic             fire         = 1'b0;
    logic [7:0]       pulse_len    = 8'h00;
    logic             active_low   = 1'b0;
    logic             start_pulse_in, busy, running, select_out, gated_state_clock, verify_data;
    logic             ref_clk;
    logic [OUT_W-1:0] timing_outputs, hold_val;
    logic [OUT_W-1:0] words [4];
    logic [OUT_W-1:0] loads [48];
    logic [4:0]       base;
    int               err_count = 0, num_checks = 0, n_loads, n_first, sel, last, n_falls;
    int               lens [3] = '{3, 4, 6};

    tps_sequencer #(.INPUT_FREQ_MHZ(100)) dut (.sys_clk(sys_clk), .resetn(resetn),
        .sync_reset(sync_reset), .start_pulse_in(start_pulse_in),
        .start_select(start_select), .timing_outputs(timing_outputs),
        .gated_state_clock(gated_state_clock), .select_out(select_out),
        .reference_clock_out(ref_clk), .running(running), .prog_mode(prog_mode),
        .prog_pulse(prog_pulse), .prog_row(prog_row), .prog_col(prog_col),
        .prog_data(prog_data), .verify_data(verify_data));
    tps_start_pulse_in_model u_start_pulse_in (.sys_clk(sys_clk), .fire(fire), .pulse_len(pulse_len),
        .active_low(active_low), .start_pulse_in(start_pulse_in), .busy(busy));

    // free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic check(string what, logic [17:0] exp, logic [17:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // inputs always move 1 ns after the rising edge
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic blow(int row, int col);
        prog_row   = 6'(row);
        prog_col   = 5'(col);
        prog_data  = 1'b1;
        prog_pulse = 1'b1;
        tick(1);
        prog_pulse = 1'b0;
        tick(2);
        check("fuse verify", 18'h1, 18'(verify_data));
    endtask : blow

    task automatic put_word(int row, logic [17:0] w);
        for (int c = 0; c < WORD_W; c++)
            if (w[c]) blow(row, c);
    endtask : put_word

    // four-word chain at base: a loop, or a line ending in a stop bit
    task automatic load_pattern(logic stop3, logic [6:0] ctrl);
        logic [4:0] nxt;
        prog_mode = 1'b1;
        prog_row  = 6'(base);
        prog_col  = 5'(STOP_COL);
        tick(2);
        check("blank fuse", 18'h0, 18'(verify_data));
        for (int i = 0; i < 4; i++)
        begin
            nxt = stop3 ? base + 5'(i + 1) : base + 5'((i + 1) % 4);
            put_word(int'(base) + i, {stop3 && i == 3, words[i], nxt});
        end
        for (int s = 0; s < START_ROWS; s++)
            put_word(32 + s, 18'(base + 5'(s % 4)));
        for (int b = 0; b < CTRL_W; b++)
            if (ctrl[b]) blow(40, 23 + b);
        prog_mode = 1'b0;
        tick(3);
    endtask : load_pattern

    // one triggered run, recording every change on the outputs
    task automatic run_pulse(int len, logic again = 1'b0);
        logic [OUT_W-1:0] prev;
        logic             run_q;
        start_select = 3'(sel);
        tick(3);
        prev      = timing_outputs;
        run_q     = 1'b0;
        n_loads   = 0;
        n_falls   = 0;
        pulse_len = 8'(len);
        fire      = 1'b1;
        tick(1);
        fire = 1'b0;
        for (int k = 0; k < 40; k++)
        begin
            tick(1);
            // optional second request, taken as the first pulse ends and the machine holds
            fire = again && k == 2;
            if (timing_outputs !== prev)
            begin
                loads[n_loads] = timing_outputs;
                n_loads++;
                prev = timing_outputs;
            end
            if (run_q && !running)
                n_falls++;
            run_q = running;
        end
        check("idle after run", 18'h0, 18'(running));
        check("ref clock in bypass", 18'h0, 18'(ref_clk));
    endtask : run_pulse

    // watchdog: the whole run needs under 9 us, so this only trips on a hang
    initial
    begin
        #100us;
        err_count++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(69040));
        for (int i = 0; i < 4; i++)
            words[i] = {8'($urandom), 4'(i + 1)};
        base = 5'($urandom % 28);
        last = 4;
        tick(20);
        resetn = 1'b1;
        tick(3);
        // looping chain, bypass clock, trailing edge stops
        load_pattern(1'b0, 7'h04);
        for (int i = 0; i < 3; i++)
        begin
            sel = $urandom % 8;
            if (sel % 4 == last) sel = (sel + 1) % 8;
            run_pulse(lens[i]);
            for (int k = 0; k < n_loads; k++)
                check("load word", 18'(words[(sel + k) % 4]), 18'(loads[k]));
            if (i == 0) n_first = n_loads;
            if (i == 0) check("min loads", 18'h1, 18'(n_loads >= 2));
            check("load count", 18'(n_first + lens[i] - lens[0]), 18'(n_loads));
            last = (sel + n_loads - 1) % 4;
        end
        // retrigger during hold: straight back to arm, idle never seen in between
        sel = (last + 1) % 4;
        run_pulse(3, 1'b1);
        check("retrigger loads", 18'h4, 18'(n_loads));
        check("retrigger word", 18'(words[sel]), 18'(loads[2]));
        check("retrigger idle gaps", 18'h1, 18'(n_falls));
        // synchronous reset in mid-run
        pulse_len = 8'd20;
        fire      = 1'b1;
        tick(1);
        fire = 1'b0;
        tick(8);
        sync_reset = 1'b1;
        tick(1);
        sync_reset = 1'b0;
        hold_val   = timing_outputs;
        tick(4);
        check("sync reset idle", 18'h0, 18'(running));
        check("sync reset keep", 18'(hold_val), 18'(timing_outputs));
        tick(20);
        // fresh fuses: falling edge, no trailing stop, stop bit on word 3
        resetn = 1'b0;
        tick(2);
        resetn = 1'b1;
        check("outputs after reset", 18'h0, 18'(timing_outputs));
        load_pattern(1'b1, 7'h64);
        active_low = 1'b1;
        tick(4);
        sel = ($urandom % 2) * 4;
        run_pulse(2);
        check("stop bit loads", 18'h4, 18'(n_loads));
        for (int k = 0; k < 4; k++)
            check("falling run word", 18'(words[k]), 18'(loads[k]));
        check("stop word held", 18'(words[3]), 18'(timing_outputs));
        give_verdict();
    end
endmodule : triggered_pattern_sequencer_tb_top
